//--- pkg/bsc_pkg.sv
/*
 * bsc_pkg: shared constants and the shift type encoding for the barrel
 * shifter with carry-out.
 * Assumes the decoder drives shift types with exactly these codes.
 */
`default_nettype none

package bsc_pkg;

	// operand and length widths
	localparam int unsigned DATA_W = 32;
	localparam int unsigned LEN_W  = 8;
	localparam int unsigned AMT_W  = 5;

	// length thresholds, at the width of the length field
	localparam logic [7:0] LEN_ZERO    = 8'h00;
	localparam logic [7:0] LEN_ONE     = 8'h01;
	localparam logic [7:0] LEN_WORD    = 8'h20; // 32: whole word out
	localparam logic [7:0] LEN_PAST    = 8'h21; // 33: carry forced low for logical shifts
	localparam logic [7:0] LEN_MAX_31  = 8'h1F; // immediate limit, lsl/ror

	// reset values of the output stage
	localparam logic [31:0] RESULT_RST = 32'h0000_0000;
	localparam logic        FLAG_RST   = 1'b0;

	// shift type encoding
	typedef enum logic [2:0] {
		SHT_ARITH_RIGHT   = 3'h0, // arith_shift_right
		SHT_LOGIC_RIGHT   = 3'h1, // logical_shift_right
		SHT_LOGIC_LEFT    = 3'h2, // logical_shift_left
		SHT_ROTATE_RIGHT  = 3'h3, // rotate_right
		SHT_ROTATE_CARRY  = 3'h4  // rotate_right_through_carry
	} bsc_shift_type;

endpackage

`default_nettype wire

//--- rtl/bsc_rotator.sv
/*
 * bsc_rotator: combinational 32-bit right rotator built as a log shifter,
 * one stage per bit of the rotate amount.
 * Assumes the caller masks and fills bits for the non-rotating shifts.
 */
`timescale 1ns/1ns
`default_nettype none

module bsc_rotator #(
	parameter int unsigned WIDTH = 32,
	parameter int unsigned AMT_W = 5
) (
	// data in
	input  wire logic [WIDTH-1:0] data_i,
	input  wire logic [AMT_W-1:0] amount_i,
	// data out
	output logic      [WIDTH-1:0] data_o
);

	logic [WIDTH-1:0] stage_w [AMT_W+1];

	assign stage_w[0] = data_i;

	////////////////////////////////////////////////////////////////////////
	// each stage rotates by a power of two when its amount bit is set
	genvar gi;
	generate
		for (gi = 0; gi < AMT_W; gi++) begin : g_stage
			localparam int unsigned SH = 1 << gi;
			assign stage_w[gi+1] = amount_i[gi] ?
				{stage_w[gi][SH-1:0], stage_w[gi][WIDTH-1:SH]} :
				stage_w[gi];
		end
	endgenerate

	assign data_o = stage_w[AMT_W];

endmodule

`default_nettype wire

//--- rtl/bsc_shifter.sv
/*
 * bsc_shifter: 32-bit barrel shifter with carry-out for an execute stage,
 * one register stage between operands and results.
 * Assumes the decoder presents operands with valid_i and that the flag
 * register loads carry_o only while carry_valid_o is high.
 */
`timescale 1ns/1ns
`default_nettype none

module bsc_shifter #(
	parameter int unsigned DATA_W = bsc_pkg::DATA_W,
	parameter int unsigned LEN_W  = bsc_pkg::LEN_W
) (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              sys_rst_i,
	// operation from the decoder
	input  wire logic              valid_i,
	input  wire logic [DATA_W-1:0] source_operand_i,
	input  wire logic [2:0]        shift_type_i,
	input  wire logic [LEN_W-1:0]  shift_len_i,
	input  wire logic              len_is_imm_i,
	input  wire logic              set_flags_i,
	input  wire logic              carry_i,
	// results to the consuming instruction and flag register
	output logic                   valid_o,
	output logic      [DATA_W-1:0] result_o,
	output logic                   carry_o,
	output logic                   carry_valid_o,
	output logic                   len_error_o
);

	logic [DATA_W-1:0] result_r;
	logic [DATA_W-1:0] result_nxt;
	logic              carry_r;
	logic              carry_nxt;
	logic              cvalid_r;
	logic              cvalid_nxt;
	logic              valid_r;
	logic              len_err_r;
	logic              len_err_nxt;

	////////////////////////////////////////////////////////////////////////
	// type decode and length classes
	wire logic is_asr  = shift_type_i == bsc_pkg::SHT_ARITH_RIGHT;
	wire logic is_lsr  = shift_type_i == bsc_pkg::SHT_LOGIC_RIGHT;
	wire logic is_lsl  = shift_type_i == bsc_pkg::SHT_LOGIC_LEFT;
	wire logic is_ror  = shift_type_i == bsc_pkg::SHT_ROTATE_RIGHT;
	wire logic is_rrx  = shift_type_i == bsc_pkg::SHT_ROTATE_CARRY;
	wire logic known_w = is_asr | is_lsr | is_lsl | is_ror | is_rrx;

	wire logic len_zero = shift_len_i == bsc_pkg::LEN_ZERO;
	wire logic len_ge32 = shift_len_i >= bsc_pkg::LEN_WORD;
	wire logic len_eq32 = shift_len_i == bsc_pkg::LEN_WORD;
	wire logic len_ge33 = shift_len_i >= bsc_pkg::LEN_PAST;
	wire logic [4:0] amt5 = shift_len_i[4:0];
	wire logic sign_w   = source_operand_i[DATA_W-1];

	////////////////////////////////////////////////////////////////////////
	// one rotator serves every type but rotate through carry; left shift rotates by 32-n
	// modulo 32 makes a rotate length above 32 act as the length modulo 32, so 33 and 65 both rotate by 1
	wire logic [4:0] rot_amt = is_lsl ? 5'(-amt5) : amt5;
	logic [DATA_W-1:0] rot_w;

	bsc_rotator #(
		.WIDTH (DATA_W),
		.AMT_W (bsc_pkg::AMT_W)
	) u_rot (
		.data_i   (source_operand_i),
		.amount_i (rot_amt),
		.data_o   (rot_w)
	);

	////////////////////////////////////////////////////////////////////////
	// masks keep the moved bits; the rest is fill
	wire logic [DATA_W-1:0] hi_keep = {DATA_W{1'b1}} >> amt5;
	wire logic [DATA_W-1:0] lo_keep = {DATA_W{1'b1}} << amt5;

	wire logic [DATA_W-1:0] asr_res = len_ge32 ? {DATA_W{sign_w}} :
		(rot_w & hi_keep) | (~hi_keep & {DATA_W{sign_w}});
	wire logic [DATA_W-1:0] lsr_res = len_ge32 ? '0 :
		(rot_w & hi_keep);
	// no overflow output exists: the top bits simply fall away
	wire logic [DATA_W-1:0] lsl_res = len_ge32 ? '0 :
		(rot_w & lo_keep);
	wire logic [DATA_W-1:0] ror_res = rot_w;
	wire logic [DATA_W-1:0] rrx_res =
		{carry_i, source_operand_i[DATA_W-1:1]};

	// the last bit out lands in bit 31 for right moves, bit 0 for left
	wire logic asr_c = len_ge32 ? sign_w : rot_w[DATA_W-1];
	wire logic lsr_c = len_ge33 ? 1'b0 :
		(len_eq32 ? sign_w : rot_w[DATA_W-1]);
	wire logic lsl_c = len_ge33 ? 1'b0 :
		(len_eq32 ? source_operand_i[0] : rot_w[0]);
	wire logic ror_c = rot_w[DATA_W-1];
	wire logic rrx_c = source_operand_i[0];

	////////////////////////////////////////////////////////////////////////
	// immediate length range check; zero means no shift and is allowed
	wire logic imm_right = is_asr | is_lsr;
	wire logic imm_bad   = len_is_imm_i & ~len_zero & ~is_rrx &
		(imm_right ? (shift_len_i > bsc_pkg::LEN_WORD)
			: (shift_len_i > bsc_pkg::LEN_MAX_31));

	// rotate through carry always moves one bit, whatever the length
	wire logic no_shift = ~known_w | (len_zero & ~is_rrx);

	////////////////////////////////////////////////////////////////////////
	// next-value selection; unknown types pass the source through
	always_comb begin
		result_nxt = source_operand_i;
		carry_nxt  = carry_i;
		if (!no_shift) begin
			unique case (shift_type_i)
				bsc_pkg::SHT_ARITH_RIGHT: begin
					result_nxt = asr_res;
					carry_nxt  = asr_c;
				end
				bsc_pkg::SHT_LOGIC_RIGHT: begin
					result_nxt = lsr_res;
					carry_nxt  = lsr_c;
				end
				bsc_pkg::SHT_LOGIC_LEFT: begin
					result_nxt = lsl_res;
					carry_nxt  = lsl_c;
				end
				bsc_pkg::SHT_ROTATE_RIGHT: begin
					result_nxt = ror_res;
					carry_nxt  = ror_c;
				end
				bsc_pkg::SHT_ROTATE_CARRY: begin
					result_nxt = rrx_res;
					carry_nxt  = rrx_c;
				end
				default: begin
					result_nxt = source_operand_i;
					carry_nxt  = carry_i;
				end
			endcase
		end
	end

	// the flag register must hold unless a real shift asked for flags
	assign cvalid_nxt  = valid_i & set_flags_i & ~no_shift;
	assign len_err_nxt = valid_i & imm_bad;

	////////////////////////////////////////////////////////////////////////
	// output stage; a result is held until the next valid operation
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			result_r  <= bsc_pkg::RESULT_RST;
			carry_r   <= bsc_pkg::FLAG_RST;
			cvalid_r  <= bsc_pkg::FLAG_RST;
			valid_r   <= bsc_pkg::FLAG_RST;
			len_err_r <= bsc_pkg::FLAG_RST;
		end else begin
			valid_r   <= valid_i;
			cvalid_r  <= cvalid_nxt;
			len_err_r <= len_err_nxt;
			if (valid_i) begin
				result_r <= result_nxt;
				carry_r  <= carry_nxt;
			end
		end
	end

	assign valid_o       = valid_r;
	assign result_o      = result_r;
	assign carry_o       = carry_r;
	assign carry_valid_o = cvalid_r;
	assign len_error_o   = len_err_r;

	////////////////////////////////////////////////////////////////////////
	// checks against the inputs of the previous cycle
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	wire logic known_op = valid_i & known_w & ~is_rrx;

	a_zero_passes: assert property (
		valid_i & len_zero & ~is_rrx |=>
			result_o == $past(source_operand_i) && !carry_valid_o &&
			carry_o == $past(carry_i))
		else $error("zero length did not pass the source through");

	a_asr_sign_fill: assert property (
		valid_i & is_asr & ~len_zero & ~len_ge32 |=>
			$signed(result_o) ==
			($signed($past(source_operand_i)) >>> $past(amt5)))
		else $error("arithmetic right result wrong");

	a_asr_carry_bit: assert property (
		valid_i & is_asr & ~len_zero & ~len_ge32 |=>
			carry_o == $past(source_operand_i[amt5 - 5'h01]))
		else $error("arithmetic right carry is not bit n-1");

	a_asr_wide_len: assert property (
		valid_i & is_asr & len_ge32 |=>
			result_o == {DATA_W{$past(sign_w)}} && carry_o == $past(sign_w))
		else $error("wide arithmetic right not all sign");

	a_lsr_zero_fill: assert property (
		valid_i & is_lsr & ~len_zero & ~len_ge32 |=>
			result_o == ($past(source_operand_i) >> $past(amt5)) &&
			carry_o == $past(source_operand_i[amt5 - 5'h01]))
		else $error("logical right result or carry wrong");

	a_lsr_carry_bit: assert property (
		valid_i & is_lsr & len_eq32 |=> carry_o == $past(sign_w))
		else $error("logical right by 32 carry not bit 31");

	a_wide_log_zero: assert property (
		valid_i & (is_lsr | is_lsl) & len_ge33 |=>
			result_o == '0 && carry_o == 1'b0)
		else $error("logical shift of 33 or more not zero");

	a_lsl_moves_up: assert property (
		valid_i & is_lsl & ~len_zero & ~len_ge32 |=>
			result_o == ($past(source_operand_i) << $past(amt5)))
		else $error("logical left result wrong");

	a_lsl_carry_bit: assert property (
		valid_i & is_lsl & ~len_zero & ~len_ge32 |=>
			carry_o == $past(source_operand_i[5'(-amt5)]))
		else $error("logical left carry is not bit 32-n");

	a_ror_wraps: assert property (
		valid_i & is_ror & ~len_zero |=>
			result_o == (({$past(source_operand_i), $past(source_operand_i)}
				>> $past(amt5)) & {{DATA_W{1'b0}}, {DATA_W{1'b1}}}))
		else $error("rotate right result wrong");

	a_ror_carry_top: assert property (
		valid_i & is_ror & ~len_zero |=>
			carry_o == $past(source_operand_i[amt5 - 5'h01]))
		else $error("rotate right carry is not the last bit rotated");

	a_ror_full_word: assert property (
		valid_i & is_ror & len_eq32 |=>
			result_o == $past(source_operand_i) && carry_o == $past(sign_w))
		else $error("rotate by 32 did not return the source");

	a_rrx_one_bit: assert property (
		valid_i & is_rrx |=>
			result_o == {$past(carry_i), $past(source_operand_i[DATA_W-1:1])}
			&& carry_o == $past(source_operand_i[0]))
		else $error("rotate through carry wrong");

	a_imm_range: assert property (
		valid_i & len_is_imm_i & is_lsl & (shift_len_i == bsc_pkg::LEN_WORD)
			|=> len_error_o)
		else $error("immediate left shift of 32 not flagged");

	a_cvalid_gate: assert property (
		carry_valid_o |-> $past(valid_i & set_flags_i & ~len_zero) ||
			$past(valid_i & set_flags_i & is_rrx))
		else $error("carry valid without a flag setting shift");

	c_asr_wide:   cover property (known_op & is_asr & len_ge32 ##1 valid_o);
	c_lsl_carry:  cover property (known_op & is_lsl & set_flags_i ##1
		carry_valid_o);
	c_ror_beyond: cover property (known_op & is_ror & len_ge33);
	c_rrx_flags:  cover property (valid_i & is_rrx & set_flags_i);

endmodule

`default_nettype wire

//--- verif/bsc_flag_model.sv
/*
 * bsc_flag_model: behavioural carry flag register behind the shifter.
 * Assumes carry_i means something only while load_i is high.
 */
`timescale 1ns/1ns
`default_nettype none

module bsc_flag_model (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	// new carry from the shifter
	input  wire logic carry_i,
	input  wire logic load_i,
	// flag seen by the next instruction
	output logic      flag_o
);
	logic flag_r;

	////////////////////////////////////////////////////////////////////////
	// load only on the strobe, so a zero-length shift leaves the flag alone
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			flag_r <= 1'b0;
		else if (load_i)
			flag_r <= carry_i;
	end

	assign flag_o = flag_r;
endmodule

`default_nettype wire

//--- verif/tb_top.sv
/*
 * tb_top: self-checking bench for bsc_shifter against a reference model.
 * Assumes the flag register model in bsc_flag_model.sv.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	logic        clk, rst, vld, imm, sf, cin;
	logic [31:0] src, r_o, p_r, rs;
	logic [2:0]  typ;
	logic [7:0]  len;
	logic        v_o, c_o, cv_o, le_o, flag;
	logic        p_v, p_c, p_cv, p_le, p_cc, ref_flag;
	logic [31:0] seed;
	int          error_cnt, n_tests;
	logic [7:0]  lens [10] = '{8'h00, 8'h01, 8'h02, 8'h1F, 8'h20,
		8'h21, 8'h3F, 8'h40, 8'h41, 8'hFF};

	bsc_shifter uut (.clk_i(clk), .sys_rst_i(rst), .valid_i(vld),
		.source_operand_i(src), .shift_type_i(typ), .shift_len_i(len),
		.len_is_imm_i(imm), .set_flags_i(sf), .carry_i(cin),
		.valid_o(v_o), .result_o(r_o), .carry_o(c_o),
		.carry_valid_o(cv_o), .len_error_o(le_o));
	bsc_flag_model fm (.clk_i(clk), .sys_rst_i(rst), .carry_i(c_o),
		.load_i(cv_o), .flag_o(flag));

	////////////////////////////////////////////////////////////////////////
	// clock and watchdog; the run needs about 500 cycles
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		$display("mismatch at %0t: watchdog expired", $time);
		stop_test();
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// reference shifter written straight from the shift definitions
	task automatic model(input logic [31:0] s, input logic [2:0] t,
		input int n, input logic ci, output logic [31:0] r,
		output logic c, output logic ch);
		int m;
		m = n % 32;
		r = s;
		c = ci;
		ch = (t < 3'h4 && n != 0) || t == 3'h4;
		if (t == 3'h4) begin
			r = {ci, s[31:1]};
			c = s[0];
		end else if (ch && t == 3'h0) begin
			// kept out of a ?: so the shift stays signed
			r = $signed(s) >>> n;
			if (n >= 32)
				r = {32{s[31]}};
			c = (n >= 32) ? s[31] : s[n-1];
		end else if (ch && t == 3'h1) begin
			r = (n >= 32) ? 32'h0000_0000 : s >> n;
			c = (n > 32) ? 1'b0 : (n == 32) ? s[31] : s[n-1];
		end else if (ch && t == 3'h2) begin
			r = (n >= 32) ? 32'h0000_0000 : s << n;
			c = (n > 32) ? 1'b0 : (n == 32) ? s[0] : s[32-n];
		end else if (ch && m != 0) begin
			r = (s >> m) | (s << (32 - m));
			c = s[m-1];
		end else if (ch)
			c = s[31];
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: %s seen %h expected %h", $time,
				what, seen, exp);
		end
	endtask

	// one falling edge: check the op in flight, then drive the next one
	task automatic step(input logic v, input logic [31:0] s,
		input logic [2:0] t, input logic [7:0] n, input logic i,
		input logic f, input logic ci);
		logic [31:0] r;
		logic        c, ch;
		@(negedge clk);
		check(v_o, p_v, "valid");
		check(r_o, p_r, "result");
		check(r_o, p_r, "result");
		check(r_o, p_r, "result");
		if (p_cc)
			check(c_o, p_c, "carry");
		check(cv_o, p_v & p_cv, "carry valid");
		check(le_o, p_v & p_le, "length error");
		check(flag, ref_flag, "flag");
		if (p_v & p_cv)
			ref_flag = p_c;
		{vld, src, typ, len, imm, sf, cin} = {v, s, t, n, i, f, ci};
		if (v) begin
			model(s, t, n, ci, r, c, ch);
			{p_r, p_c, p_cv, p_cc} = {r, c, f & ch, f | ~ch};
			p_le = i && ((t < 3'h2 && n > 8'h20) ||
				((t == 3'h2 || t == 3'h3) && n > 8'h1F));
		end
		p_v = v;
	endtask

	task automatic do_reset(input int cyc);
		@(negedge clk);
		rst = 1'b1;
		vld = 1'b0;
		repeat (cyc) @(negedge clk);
		{p_v, p_r, p_c, p_cc, ref_flag} = {1'b0, 32'h0000_0000, 3'h2};
		rst = 1'b0;
	endtask

	task automatic stop_test;
		$display("counts: %0d compares, %0d mismatches", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{rst, vld, src, typ, len, imm, sf, cin} = {1'b1, 47'h0};
		{error_cnt, n_tests} = {32'h0, 32'h0};
		seed = 32'h0000_005A;
		do_reset(12);
		// every type against the edge lengths, back to back
		foreach (lens[j])
			for (int t = 0; t < 8; t++) begin
				seed = lfsr(seed);
				step(1'b1, seed, 3'(t), lens[j], t < 5, seed[3], seed[7]);
			end
		step(1'b0, 32'h0000_0000, 3'h0, 8'h00, 1'b0, 1'b0, 1'b0);
		$display("test directed done");
		// random ops with idle gaps, so held outputs are checked too
		repeat (400) begin
			seed = lfsr(seed);
			rs = lfsr(seed);
			step(seed[17] | seed[18], rs, seed[2:0], seed[15:8],
				seed[16] & (seed[2:0] < 3'h5), seed[19], seed[20]);
			seed = rs;
		end
		$display("test random done");
		// reset in mid-stream, an op in flight is dropped
		step(1'b1, 32'h8000_0001, 3'h0, 8'h01, 1'b0, 1'b1, 1'b0);
		do_reset(2);
		step(1'b1, 32'h8000_0001, 3'h0, 8'h01, 1'b0, 1'b1, 1'b0);
		step(1'b1, 32'h0000_0001, 3'h4, 8'h00, 1'b1, 1'b1, 1'b1);
		step(1'b0, 32'h0000_0000, 3'h0, 8'h00, 1'b0, 1'b0, 1'b0);
		step(1'b0, 32'h0000_0000, 3'h0, 8'h00, 1'b0, 1'b0, 1'b0);
		$display("test reset done");
		stop_test();
	end
endmodule

`default_nettype wire
